// ==== rtl/converter_i2c_pkg.sv ====
package converter_i2c_pkg;

    // ----------------------------------------
    // Bus addresses and register space
    // ----------------------------------------
    localparam logic [6:0] TARGET_ADDR_LOW = 7'h74;
    localparam logic [6:0] TARGET_ADDR_HIGH = 7'h75;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [2:0] REG_REF_LOW = 3'h0;
    localparam logic [2:0] REG_REF_HIGH = 3'h1;
    localparam logic [2:0] REG_CURRENT_LIMIT = 3'h2;
    localparam logic [2:0] REG_SLEW_RATE = 3'h3;
    localparam logic [2:0] REG_FEEDBACK_SEL = 3'h4;
    localparam logic [2:0] REG_CABLE_COMP = 3'h5;
    localparam logic [2:0] REG_MODE_CTRL = 3'h6;
    localparam logic [2:0] REG_STATUS = 3'h7;

    // Byte 7 down to byte 0
    localparam logic [63:0] REG_RESET_IMAGE = 64'h0000_0000_01e4_01a4;
    localparam logic [63:0] REG_WRITE_MASK = 64'h00ff_07ff_33ff_07ff;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MODE_OE_BIT = 7;
    localparam int MODE_FIXED_FREQ_BIT = 1;
    localparam int LIMIT_EN_BIT = 7;
    localparam int REF_HIGH_WIDTH = 3;
    localparam int LIMIT_CODE_WIDTH = 7;
    localparam int CABLE_COMP_WIDTH = 3;
    localparam int STATUS_SWITCHING_BIT = 0;
    localparam int STATUS_SOFT_START_BIT = 1;
    localparam int STATUS_OVER_TEMP_BIT = 2;
    localparam int LINK_BUSY_BIT = 0;
    localparam int LINK_ADDRESSED_BIT = 1;
    localparam int LINK_ADDR_SEL_BIT = 2;

    // ----------------------------------------
    // Bus slave map
    // ----------------------------------------
    localparam logic [5:0] WB_LINK_STATUS_IDX = 6'h08;

    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    localparam int CLK_RATE_KHZ = 125000;
    localparam int STD_RATE_KBPS = 100;
    localparam int FAST_PLUS_RATE_KBPS = 1000;
    localparam int FAST_PLUS_BIT_CYCLES = CLK_RATE_KHZ / FAST_PLUS_RATE_KBPS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_LOAD, ST_TX, ST_RACK, ST_WAIT
    } link_state_type;

    typedef enum logic [1:0] {
        PH_ADDR, PH_PTR, PH_DATA
    } byte_phase_type;

endpackage

// ==== rtl/converter_if.sv ====
`timescale 1ns/1ps
interface reg_port_if;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic clear;
    logic [7:0] status;
    logic [63:0] image;
    modport bank (input wr_en, wr_addr, wr_data, clear, status, output image);
    modport user (output wr_en, wr_addr, wr_data, clear, status, input image);
endinterface

interface bus_event_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic addr_sel;
    logic enable;
    logic over_temp;
    modport source (output scl_rise, scl_fall, start, stop, sda, addr_sel, enable, over_temp);
    modport sink (input scl_rise, scl_fall, start, stop, sda, addr_sel, enable, over_temp);
endinterface

// ==== rtl/pin_sampler.sv ====
`timescale 1ns/1ps
module pin_sampler
    import converter_i2c_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic addr_select_i,
    input wire logic enable_undervoltage_pin_i,
    input wire logic over_temp_i,
    bus_event_if.source ev
);

    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic [1:0] prev_ff;
    logic [4:0] nxt_meta;
    logic [4:0] nxt_sync;
    logic [1:0] nxt_prev;

    // ----------------------------------------
    // Two-stage sampling
    // ----------------------------------------
    always_comb begin
        nxt_meta = {over_temp_i, enable_undervoltage_pin_i, addr_select_i, sda_i, scl_i};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff[1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 5'h03;
            sync_ff <= 5'h03;
            prev_ff <= 2'h3;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // ----------------------------------------
    // Edge and condition detection
    // ----------------------------------------
    always_comb begin
        ev.scl_rise = sync_ff[0] & ~prev_ff[0];
        ev.scl_fall = ~sync_ff[0] & prev_ff[0];
        ev.start = sync_ff[0] & prev_ff[0] & prev_ff[1] & ~sync_ff[1];
        ev.stop = sync_ff[0] & prev_ff[0] & ~prev_ff[1] & sync_ff[1];
        ev.sda = sync_ff[1];
        ev.addr_sel = sync_ff[2];
        ev.enable = sync_ff[3];
        ev.over_temp = sync_ff[4];
    end

endmodule

// ==== rtl/reg_bank.sv ====
`timescale 1ns/1ps
module reg_bank
    import converter_i2c_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    reg_port_if.bank rp
);

    // ----------------------------------------
    // Eight byte registers
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_reg
            logic [7:0] val_ff;
            logic [7:0] nxt_val;
            localparam logic [7:0] RST_VAL = REG_RESET_IMAGE[i*8 +: 8];
            localparam logic [7:0] MASK = REG_WRITE_MASK[i*8 +: 8];

            always_comb begin
                nxt_val = val_ff;
                if (rp.clear) begin
                    nxt_val = RST_VAL;
                end else if (i == REG_STATUS) begin
                    nxt_val = rp.status;
                end else if (rp.wr_en && rp.wr_addr == 3'(i)) begin
                    nxt_val = (val_ff & ~MASK) | (rp.wr_data & MASK);
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    val_ff <= RST_VAL;
                end else begin
                    val_ff <= nxt_val;
                end
            end

            assign rp.image[i*8 +: 8] = val_ff;
        end
    endgenerate

endmodule

// ==== rtl/converter_i2c_target_regs.sv ====
`timescale 1ns/1ps
module converter_i2c_target_regs
    import converter_i2c_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_i,
    input wire logic enable_undervoltage_pin_i,
    input wire logic over_temp_i,
    output logic [10:0] ref_setting_o,
    output logic [LIMIT_CODE_WIDTH-1:0] current_limit_code_o,
    output logic current_limit_en_o,
    output logic [CABLE_COMP_WIDTH-1:0] cable_droop_comp_o,
    output logic forced_fixed_freq_o,
    output logic pulse_skip_light_load_o,
    output logic switching_en_o,
    output logic soft_start_reset_o,
    output logic bus_busy_o
);

    reg_port_if rp ();
    bus_event_if ev ();

    pin_sampler i_pin_sampler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_select_i(addr_select_i),
        .enable_undervoltage_pin_i(enable_undervoltage_pin_i),
        .over_temp_i(over_temp_i),
        .ev(ev)
    );

    reg_bank i_reg_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rp(rp)
    );

    function automatic logic [7:0] reg_byte(input logic [63:0] img, input logic [7:0] idx);
        reg_byte = (idx < REG_COUNT) ? img[{idx[2:0], 3'h0} +: 8] : 8'h00;
    endfunction

    function automatic logic is_defined(input logic [7:0] idx);
        is_defined = idx < REG_COUNT;
    endfunction

    // ----------------------------------------
    // Link state
    // ----------------------------------------
    link_state_type state_ff, nxt_state;
    byte_phase_type phase_ff, nxt_phase;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] ptr_ff, nxt_ptr;
    logic rw_ff, nxt_rw;
    logic mack_ff, nxt_mack;
    logic sda_oe_ff, nxt_sda_oe;
    logic scl_oe_ff, nxt_scl_oe;
    logic busy_ff, nxt_busy;
    logic i2c_wr;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;

    assign own_addr = ev.addr_sel ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;
    assign rd_byte = reg_byte(rp.image, ptr_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_mack = mack_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_scl_oe = 1'b0;
        nxt_busy = busy_ff;
        i2c_wr = 1'b0;
        if (ev.start) begin
            nxt_busy = 1'b1;
            nxt_state = ST_RX;
            nxt_phase = PH_ADDR;
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end else if (ev.stop) begin
            nxt_busy = 1'b0;
            nxt_state = ST_IDLE;
            nxt_sda_oe = 1'b0;
        end else begin
            case (state_ff)
                ST_RX: begin
                    if (ev.scl_rise) begin
                        nxt_shift = {shift_ff[6:0], ev.sda};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (ev.scl_fall && cnt_ff == BYTE_BITS) begin
                        nxt_state = ST_WAIT;
                        case (phase_ff)
                            PH_ADDR: begin
                                if (shift_ff[7:1] == own_addr) begin
                                    nxt_rw = shift_ff[0];
                                    nxt_sda_oe = 1'b1;
                                    nxt_state = ST_ACK;
                                end
                            end
                            PH_PTR: begin
                                if (is_defined(shift_ff)) begin
                                    nxt_ptr = shift_ff;
                                    nxt_sda_oe = 1'b1;
                                    nxt_state = ST_ACK;
                                end
                            end
                            default: begin
                                if (is_defined(ptr_ff)) begin
                                    i2c_wr = 1'b1;
                                    nxt_ptr = ptr_ff + 8'h01;
                                    nxt_sda_oe = 1'b1;
                                    nxt_state = ST_ACK;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (ev.scl_fall) begin
                        nxt_sda_oe = 1'b0;
                        nxt_cnt = 4'h0;
                        if (phase_ff == PH_ADDR && rw_ff) begin
                            nxt_scl_oe = 1'b1;
                            nxt_state = ST_LOAD;
                        end else begin
                            nxt_state = ST_RX;
                            nxt_phase = (phase_ff == PH_ADDR) ? PH_PTR : PH_DATA;
                        end
                    end
                end
                ST_LOAD: begin
                    nxt_shift = rd_byte;
                    nxt_sda_oe = ~rd_byte[7];
                    nxt_ptr = ptr_ff + 8'h01;
                    nxt_cnt = 4'h0;
                    nxt_state = ST_TX;
                end
                ST_TX: begin
                    if (ev.scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (ev.scl_fall) begin
                        if (cnt_ff == BYTE_BITS) begin
                            nxt_sda_oe = 1'b0;
                            nxt_state = ST_RACK;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_sda_oe = ~shift_ff[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (ev.scl_rise) begin
                        nxt_mack = ~ev.sda;
                    end else if (ev.scl_fall) begin
                        if (mack_ff) begin
                            nxt_scl_oe = 1'b1;
                            nxt_state = ST_LOAD;
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: nxt_state = ST_WAIT;
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            phase_ff <= PH_ADDR;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            mack_ff <= nxt_mack;
            sda_oe_ff <= nxt_sda_oe;
            scl_oe_ff <= nxt_scl_oe;
            busy_ff <= nxt_busy;
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic wb_req;
    logic wb_wr;
    logic [5:0] wb_idx;
    logic [7:0] link_status;

    assign wb_idx = adr_i[7:2];
    assign wb_req = cyc_i & stb_i & ~ack_ff & ~i2c_wr;
    assign wb_wr = wb_req & we_i & sel_i[0] & (wb_idx < 6'(REG_COUNT));

    always_comb begin
        link_status = 8'h00;
        link_status[LINK_BUSY_BIT] = busy_ff;
        link_status[LINK_ADDRESSED_BIT] = (state_ff != ST_IDLE) && (state_ff != ST_WAIT);
        link_status[LINK_ADDR_SEL_BIT] = ev.addr_sel;
    end

    always_comb begin
        nxt_ack = wb_req;
        nxt_dat = dat_ff;
        if (wb_req) begin
            if (wb_idx == WB_LINK_STATUS_IDX) begin
                nxt_dat = {24'h00_0000, link_status};
            end else begin
                nxt_dat = {24'h00_0000, reg_byte(rp.image, {2'h0, wb_idx})};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // ----------------------------------------
    // Register bank port
    // ----------------------------------------
    always_comb begin
        rp.wr_en = i2c_wr | wb_wr;
        rp.wr_addr = i2c_wr ? ptr_ff[2:0] : wb_idx[2:0];
        rp.wr_data = i2c_wr ? shift_ff : dat_i[7:0];
        rp.clear = ~ev.enable;
        rp.status = 8'h00;
        rp.status[STATUS_SWITCHING_BIT] = switching_en_o;
        rp.status[STATUS_SOFT_START_BIT] = soft_start_reset_o;
        rp.status[STATUS_OVER_TEMP_BIT] = ev.over_temp;
    end

    // ----------------------------------------
    // Converter controls
    // ----------------------------------------
    logic [7:0] mode_byte;
    logic [7:0] limit_byte;
    logic nxt_switching;
    logic nxt_ss_reset;

    assign mode_byte = rp.image[{REG_MODE_CTRL, 3'h0} +: 8];
    assign limit_byte = rp.image[{REG_CURRENT_LIMIT, 3'h0} +: 8];

    always_comb begin
        nxt_switching = ev.enable & mode_byte[MODE_OE_BIT] & ~ev.over_temp;
        nxt_ss_reset = ~nxt_switching;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_setting_o <= 11'h000;
            current_limit_code_o <= '0;
            current_limit_en_o <= 1'b0;
            cable_droop_comp_o <= '0;
            forced_fixed_freq_o <= 1'b0;
            pulse_skip_light_load_o <= 1'b1;
            switching_en_o <= 1'b0;
            soft_start_reset_o <= 1'b1;
        end else begin
            ref_setting_o <= {rp.image[{REG_REF_HIGH, 3'h0} +: REF_HIGH_WIDTH],
                              rp.image[{REG_REF_LOW, 3'h0} +: 8]};
            current_limit_code_o <= limit_byte[LIMIT_CODE_WIDTH-1:0];
            current_limit_en_o <= limit_byte[LIMIT_EN_BIT];
            cable_droop_comp_o <= rp.image[{REG_CABLE_COMP, 3'h0} +: CABLE_COMP_WIDTH];
            forced_fixed_freq_o <= mode_byte[MODE_FIXED_FREQ_BIT];
            pulse_skip_light_load_o <= ~mode_byte[MODE_FIXED_FREQ_BIT];
            switching_en_o <= nxt_switching;
            soft_start_reset_o <= nxt_ss_reset;
        end
    end

    // ----------------------------------------
    // Pin and bus outputs
    // ----------------------------------------
    assign sda_oe_o = sda_oe_ff;
    assign scl_oe_o = scl_oe_ff;
    assign bus_busy_o = busy_ff;
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
        scl_o <= 1'b0;
    end

endmodule

// ==== sim/converter_i2c_target_regs_assertions.sv ====
`timescale 1ns/1ps
module converter_i2c_target_regs_checker
    import converter_i2c_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic scl_i,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_oe_o,
    input wire logic enable_undervoltage_pin_i,
    input wire logic over_temp_i,
    input wire logic current_limit_en_o,
    input wire logic [CABLE_COMP_WIDTH-1:0] cable_droop_comp_o,
    input wire logic forced_fixed_freq_o,
    input wire logic pulse_skip_light_load_o,
    input wire logic switching_en_o,
    input wire logic soft_start_reset_o,
    input wire logic bus_busy_o
);
    // ----
    // Port relations
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_mode_pair; pulse_skip_light_load_o != forced_fixed_freq_o; endproperty
    a_mode_pair: assert property (p_mode_pair) else $error("light load modes clash");
    property p_soft_start; soft_start_reset_o == !switching_en_o; endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft start mismatch");
    property p_hot_stop; over_temp_i [*6] |-> !switching_en_o; endproperty
    a_hot_stop: assert property (p_hot_stop) else $error("switching while hot");
    property p_enable_low;
        !enable_undervoltage_pin_i [*6] |=> cable_droop_comp_o == 3'h0 && current_limit_en_o
            && !forced_fixed_freq_o && !switching_en_o;
    endproperty
    a_enable_low: assert property (p_enable_low) else $error("defaults not restored");
    property p_sda_when_low; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_sda_when_low: assert property (p_sda_when_low) else $error("data moved with clock high");
    property p_stretch_short; scl_oe_o |=> !scl_oe_o; endproperty
    a_stretch_short: assert property (p_stretch_short) else $error("clock held too long");
    property p_busy_start; $fell(sda_i) && scl_i ##1 scl_i [*4] |-> ##[0:4] bus_busy_o; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not set");
    property p_free_stop; $rose(sda_i) && scl_i ##1 scl_i [*4] |-> ##[0:4] !bus_busy_o; endproperty
    a_free_stop: assert property (p_free_stop) else $error("busy not cleared");
endmodule
bind converter_i2c_target_regs converter_i2c_target_regs_checker i_checker (.clk_i, .rst_i, .cyc_i, .stb_i,
    .ack_o, .scl_i, .scl_oe_o, .sda_i, .sda_oe_o, .enable_undervoltage_pin_i, .over_temp_i, .current_limit_en_o,
    .cable_droop_comp_o, .forced_fixed_freq_o, .pulse_skip_light_load_o, .switching_en_o, .soft_start_reset_o,
    .bus_busy_o);

// ==== sim/i2c_controller_model.sv ====
`timescale 1ns/1ps
module i2c_controller_model (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o,
    output logic timeout_o
);
    // ----
    // Bus controller
    // ----
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
        timeout_o = 1'b0;
    end
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bit_io(input logic b, output logic s);
        int guard;
        guard = 0;
        wait_cycles(2);
        sda_low_o <= !b;
        wait_cycles(6);
        scl_low_o <= 1'b0;
        wait_cycles(1);
        while (!scl_i && guard < 1000) begin
            guard++;
            @(posedge clk_i);
        end
        if (guard >= 1000) timeout_o <= 1'b1;
        wait_cycles(4);
        s = sda_i;
        wait_cycles(3);
        scl_low_o <= 1'b1;
    endtask
    // Also serves as repeated start
    task automatic start_cond();
        wait_cycles(2);
        sda_low_o <= 1'b0;
        wait_cycles(6);
        scl_low_o <= 1'b0;
        wait_cycles(8);
        sda_low_o <= 1'b1;
        wait_cycles(8);
        scl_low_o <= 1'b1;
    endtask
    task automatic stop_cond();
        wait_cycles(2);
        sda_low_o <= 1'b1;
        wait_cycles(6);
        scl_low_o <= 1'b0;
        wait_cycles(8);
        sda_low_o <= 1'b0;
        wait_cycles(8);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(!ack, s);
    endtask
endmodule

// ==== sim/tb_converter_i2c_target_regs.sv ====
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module tb_converter_i2c_target_regs
    import converter_i2c_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, addr_select_i = 1'b0;
    logic enable_undervoltage_pin_i = 1'b1, over_temp_i = 1'b0, ack_o, scl_oe_o, sda_oe_o, scl_low, sda_low;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic [LIMIT_CODE_WIDTH-1:0] current_limit_code_o;
    logic [CABLE_COMP_WIDTH-1:0] cable_droop_comp_o;
    logic current_limit_en_o, forced_fixed_freq_o, pulse_skip_light_load_o, switching_en_o;
    logic soft_start_reset_o, bus_busy_o, ctrl_timeout, scl_o, sda_o;
    logic [10:0] ref_setting_o;
    wire scl_i = !(scl_low || scl_oe_o);
    wire sda_i = !(sda_low || sda_oe_o);
    int fail_count = 0;
    int samples_checked = 0;
    always #4 clk_i = ~clk_i;
    converter_i2c_target_regs i_converter_i2c_target_regs (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .addr_select_i,
        .enable_undervoltage_pin_i, .over_temp_i, .ref_setting_o, .current_limit_code_o, .current_limit_en_o,
        .cable_droop_comp_o, .forced_fixed_freq_o, .pulse_skip_light_load_o, .switching_en_o,
        .soft_start_reset_o, .bus_busy_o);
    i2c_controller_model i_ctrl (.clk_i, .scl_i, .sda_i, .scl_low_o(scl_low), .sda_low_o(sda_low),
        .timeout_o(ctrl_timeout));
    // ----
    // Shared tasks
    // ----
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        int guard;
        guard = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && guard < 20) begin
            guard++;
            @(posedge clk_i);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        if (guard >= 20) begin
            fail_count++;
            $display("BAD %0t bus wait expired", $time);
            stop_test();
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic reset_values();
        logic [31:0] q;
        for (int n = 0; n < 7; n++) begin
            wb_cycle(8'(4 * n), 1'b0, 8'h00, q);
            `CHECK(q, {24'h00_0000, REG_RESET_IMAGE[8*n +: 8]})
        end
        wb_cycle(8'h24, 1'b0, 8'h00, q);
        `CHECK(q, 32'h0000_0000)
        `CHECK(pulse_skip_light_load_o, 1'b1)
        `CHECK(cable_droop_comp_o, 3'h0)
        `CHECK(current_limit_en_o, 1'b1)
        `CHECK(ref_setting_o, 11'h1a4)
        `CHECK({scl_o, sda_o}, 2'h0)
    endtask
    task automatic i2c_write_mode();
        logic [3:0] a;
        i_ctrl.start_cond();
        i_ctrl.send_byte(8'he8, a[3]);
        `CHECK(bus_busy_o, 1'b1)
        i_ctrl.send_byte(8'h05, a[2]);
        i_ctrl.send_byte(8'h03, a[1]);
        i_ctrl.send_byte(8'h82, a[0]);
        i_ctrl.stop_cond();
        `CHECK(a, 4'hf)
        `CHECK(bus_busy_o, 1'b0)
        `CHECK(cable_droop_comp_o, 3'h3)
        `CHECK({forced_fixed_freq_o, pulse_skip_light_load_o}, 2'h2)
        `CHECK(switching_en_o, 1'b1)
    endtask
    task automatic i2c_read_back();
        logic [2:0] a;
        logic [23:0] d;
        logic [31:0] q;
        wb_cycle(8'h18, 1'b1, 8'h02, q);
        @(posedge clk_i);
        `CHECK(switching_en_o, 1'b0)
        i_ctrl.start_cond();
        i_ctrl.send_byte(8'he8, a[2]);
        i_ctrl.send_byte(8'h04, a[1]);
        i_ctrl.start_cond();
        i_ctrl.send_byte(8'he9, a[0]);
        i_ctrl.recv_byte(1'b1, d[23:16]);
        i_ctrl.recv_byte(1'b1, d[15:8]);
        i_ctrl.recv_byte(1'b0, d[7:0]);
        i_ctrl.stop_cond();
        `CHECK(a, 3'h7)
        `CHECK(d, 24'h00_0302)
    endtask
    task automatic i2c_refusals();
        logic [3:0] a;
        logic [31:0] q;
        i_ctrl.start_cond();
        i_ctrl.send_byte(8'hea, a[3]);
        i_ctrl.send_byte(8'h00, a[2]);
        i_ctrl.stop_cond();
        addr_select_i <= 1'b1;
        i_ctrl.start_cond();
        i_ctrl.send_byte(8'hea, a[1]);
        i_ctrl.send_byte(8'h08, a[0]);
        i_ctrl.stop_cond();
        wb_cycle(8'h20, 1'b0, 8'h00, q);
        `CHECK(q, 32'h0000_0004)
        addr_select_i <= 1'b0;
        `CHECK(a[3:2], 2'h0)
        `CHECK(a[1], 1'b1)
        `CHECK(a[0], 1'b0)
    endtask
    task automatic protection();
        logic [31:0] q;
        wb_cycle(8'h08, 1'b1, 8'h10, q);
        wb_cycle(8'h18, 1'b1, 8'h80, q);
        wb_cycle(8'h00, 1'b1, 8'h34, q);
        wb_cycle(8'h04, 1'b1, 8'h03, q);
        @(posedge clk_i);
        `CHECK(ref_setting_o, 11'h334)
        `CHECK({current_limit_en_o, current_limit_code_o}, 8'h10)
        `CHECK(switching_en_o, 1'b1)
        over_temp_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHECK(soft_start_reset_o, 1'b1)
        wb_cycle(8'h1c, 1'b0, 8'h00, q);
        `CHECK(q, 32'h0000_0006)
        over_temp_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        `CHECK(switching_en_o, 1'b1)
        wb_cycle(8'h08, 1'b0, 8'h00, q);
        `CHECK(q, 32'h0000_0010)
        enable_undervoltage_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        enable_undervoltage_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb_cycle(8'h08, 1'b0, 8'h00, q);
        `CHECK(q, 32'h0000_00e4)
        `CHECK(switching_en_o, 1'b0)
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        reset_values();
        i2c_write_mode();
        i2c_read_back();
        i2c_refusals();
        protection();
        `CHECK(ctrl_timeout, 1'b0)
        stop_test();
    end
endmodule
